//--- verilog/tdp_host.sv
// Host controller driving the transmit descriptor and data phases of the core
// Contract
// RULE_01: Raise framing with request when payload present; the code raises it only when more than one data cycle follows
// RULE_02: Hold framing until cycle before last data
// RULE_03: Valid from cycle after framing through last
// RULE_04: Data advances only when valid and no wait
// RULE_05: No data accepted before descriptor acknowledge
// RULE_06: Three-doubleword header data may meet acknowledge
// RULE_07: Core stalls with wait for link priorities
// RULE_08: Core waits when it cannot acknowledge next
// RULE_09: Two doublewords per cycle, natural lane positions
// RULE_10: Alignment bit at 2 or 34 by bit 125
// RULE_11: Address bit picks low or high first lane
// RULE_12: Data cycle count matches length and address
// RULE_13: Wrong cycle count hangs the core interface
// RULE_14: Signal set per channel, index 0 or 1
// RULE_15: Hold request and descriptor until acknowledge
// RULE_16: Acknowledge is one cycle, next request follows
// RULE_17: Bit 126 says whether payload follows
// RULE_18: Length in doublewords at bits 105:96
// RULE_19: All handshakes on rising clock edge
`timescale 1ns/100ps
module tdp_host #(
  parameter int VC_SEL = 0   // Channel whose signal set this host drives
) (
  input  wire logic                       mclk_in,
  input  wire logic                       reset_n_in,
  // User side: load payload, then start a packet
  input  wire logic                       pay_wr_en_in,
  input  wire logic [tdp_pkg::PAY_AW-1:0] pay_wr_addr_in,
  input  wire logic [tdp_pkg::DW_W-1:0]   pay_wr_data_in,
  input  wire logic                       start_in,
  input  wire logic [tdp_pkg::DESC_W-1:0] start_desc_in,
  output logic                            busy_out,
  output logic                            done_out,
  // Core side signal set of one channel
  output logic                            tx_req_out,
  output logic [tdp_pkg::DESC_W-1:0]      tx_desc_out,
  input  wire logic                       tx_ack_in,
  output logic                            tx_dfr_out,
  output logic                            payload_valid_out,
  input  wire logic                       throttle_wait_in,
  output logic [tdp_pkg::DATA_W-1:0]      tx_data_out
);
  // Only channel 0 or 1 exists on the core
  localparam bit VC_OK = (VC_SEL >= 0) && (VC_SEL < tdp_pkg::MAX_VC);  // [RULE_14]

  tdp_pkg::tdp_state_type state_ff, nxt_state;  // Sequencer state

  logic [tdp_pkg::DESC_W-1:0] desc_ff;     // Held descriptor
  logic [10:0]                cyc_left_ff; // Data cycles still to go, this one included
  logic [10:0]                beat_idx_ff; // Data beats taken so far in this packet
  logic                       lane_hi_ff;  // First doubleword goes in high lane
  logic                       acked_ff;    // Descriptor acknowledged already
  logic                       first_ff;    // First data cycle of packet pending
  logic                       primed_ff;   // Read banks hold the beat on offer
  logic [tdp_pkg::DW_W-1:0]   even_rd;     // Even-doubleword bank read data
  logic [tdp_pkg::DW_W-1:0]   odd_rd;      // Odd-doubleword bank read data

  // Doubleword count from the length field, zero meaning the maximum
  function automatic logic [10:0] dw_count(input logic [tdp_pkg::DESC_W-1:0] d);
    logic [tdp_pkg::LEN_W-1:0] len;
    len = d[tdp_pkg::LEN_HI:tdp_pkg::LEN_LO];                            // [RULE_18]
    dw_count = (len == '0) ? 11'h400 : {1'b0, len};
  endfunction

  // Selected address bit 2, by header size
  function automatic logic addr_bit2(input logic [tdp_pkg::DESC_W-1:0] d);
    addr_bit2 = d[tdp_pkg::HDR4_BIT] ? d[tdp_pkg::ADDR2_4DW]
                                     : d[tdp_pkg::ADDR2_3DW];            // [RULE_10]
  endfunction

  // Decode of the incoming descriptor
  wire        start_has_data = start_desc_in[tdp_pkg::HAS_DATA_BIT];     // [RULE_17]
  wire        start_hi       = addr_bit2(start_desc_in);
  wire [10:0] start_dws      = dw_count(start_desc_in);
  // Cycles = (doublewords + offset lane + 1) / 2
  wire [11:0] start_sum      = {1'b0, start_dws} + {11'h000, start_hi} + 12'h001;
  wire [10:0] start_cycles   = start_sum[11:1];                          // [RULE_12]

  // A beat is taken by the core only when valid and not stalled
  wire in_data   = (state_ff == tdp_pkg::ST_DATA);
  wire beat      = in_data && payload_valid_out && !throttle_wait_in;    // [RULE_04] [RULE_07] [RULE_08]
  wire last_beat = beat && (cyc_left_ff == 11'h001);
  wire req_phase = (state_ff == tdp_pkg::ST_REQ) ||
                   (in_data && !acked_ff);
  wire ack_seen  = req_phase && tx_ack_in;                               // [RULE_16] [RULE_19]

  // Lane content: first beat may fill only the high lane
  wire first_hi  = first_ff && lane_hi_ff;                               // [RULE_11]

  // Sequencer next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      tdp_pkg::ST_IDLE: begin
        if (start_in && VC_OK) begin
          nxt_state = start_has_data ? tdp_pkg::ST_DATA : tdp_pkg::ST_REQ;  // [RULE_01]
        end
      end
      tdp_pkg::ST_REQ: begin
        if (tx_ack_in) begin
          nxt_state = tdp_pkg::ST_DONE;
        end
      end
      tdp_pkg::ST_DATA: begin
        // Packet ends after the final beat once the acknowledge is in
        if (last_beat && (acked_ff || tx_ack_in)) begin
          nxt_state = tdp_pkg::ST_DONE;
        end else if (last_beat) begin
          nxt_state = tdp_pkg::ST_REQ;
        end
      end
      tdp_pkg::ST_DONE: nxt_state = tdp_pkg::ST_IDLE;
      default:          nxt_state = tdp_pkg::ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff <= tdp_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Packet bookkeeping
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      desc_ff     <= '0;
      cyc_left_ff <= '0;
      beat_idx_ff <= '0;
      lane_hi_ff  <= 1'b0;
      acked_ff    <= 1'b0;
      first_ff    <= 1'b0;
    end else if (state_ff == tdp_pkg::ST_IDLE && start_in && VC_OK) begin
      desc_ff     <= start_desc_in;                                      // [RULE_15]
      cyc_left_ff <= start_cycles;
      beat_idx_ff <= '0;
      lane_hi_ff  <= start_hi;
      acked_ff    <= 1'b0;
      first_ff    <= 1'b1;
    end else begin
      if (ack_seen) begin
        acked_ff <= 1'b1;
      end
      if (beat) begin
        cyc_left_ff <= cyc_left_ff - 11'h001;
        beat_idx_ff <= beat_idx_ff + 11'h001;
        first_ff    <= 1'b0;
      end
    end
  end

  // Payload sits in two banks by doubleword parity, so one read of each
  // bank gives a whole beat every cycle and valid never has to gap.
  // Read ahead: on a beat the banks already fetch the following one.
  wire [10:0] fetch_idx = beat ? (beat_idx_ff + 11'h001) : beat_idx_ff;
  // With a high-lane start the low lane trails by one odd doubleword
  wire [10:0] odd_idx   = fetch_idx - {10'h000, lane_hi_ff};            // [RULE_11]
  wire [tdp_pkg::PAY_AW-2:0] even_addr    = fetch_idx[tdp_pkg::PAY_AW-2:0];
  wire [tdp_pkg::PAY_AW-2:0] odd_addr     = odd_idx[tdp_pkg::PAY_AW-2:0];
  wire [tdp_pkg::PAY_AW-2:0] bank_wr_addr = pay_wr_addr_in[tdp_pkg::PAY_AW-1:1];
  wire                       even_wr_en   = pay_wr_en_in && !pay_wr_addr_in[0];
  wire                       odd_wr_en    = pay_wr_en_in && pay_wr_addr_in[0];

  // Bank of even doublewords, word k at k/2
  tdp_pay_mem #(
    .WIDTH (tdp_pkg::DW_W),
    .DEPTH (tdp_pkg::PAY_DEPTH / 2),
    .AW    (tdp_pkg::PAY_AW - 1)
  ) u_even_mem (
    .mclk_in     (mclk_in),
    .wr_en_in    (even_wr_en),
    .wr_addr_in  (bank_wr_addr),
    .wr_data_in  (pay_wr_data_in),
    .rd_addr_in  (even_addr),
    .rd_data_out (even_rd)
  );

  // Bank of odd doublewords, word k at k/2
  tdp_pay_mem #(
    .WIDTH (tdp_pkg::DW_W),
    .DEPTH (tdp_pkg::PAY_DEPTH / 2),
    .AW    (tdp_pkg::PAY_AW - 1)
  ) u_odd_mem (
    .mclk_in     (mclk_in),
    .wr_en_in    (odd_wr_en),
    .wr_addr_in  (bank_wr_addr),
    .wr_data_in  (pay_wr_data_in),
    .rd_addr_in  (odd_addr),
    .rd_data_out (odd_rd)
  );

  // Read data is good from the second data-phase cycle on, which is the
  // cycle after framing rises; one fetch cycle per packet is the price.
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      primed_ff <= 1'b0;
    end else begin
      primed_ff <= in_data && !last_beat;                                // [RULE_03]
    end
  end

  // Lanes follow the selected address bit
  wire [tdp_pkg::DW_W-1:0] lo_lane = lane_hi_ff ? odd_rd : even_rd;     // [RULE_09]
  wire [tdp_pkg::DW_W-1:0] hi_lane = lane_hi_ff ? even_rd : odd_rd;     // [RULE_11]
  // Framing stays high until the cycle before the last data cycle
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_dfr_out <= 1'b0;
    end else if (state_ff == tdp_pkg::ST_IDLE && start_in && VC_OK) begin
      tx_dfr_out <= start_has_data && (start_cycles > 11'h001);          // [RULE_01]
    end else if (in_data) begin
      // Drop when the beat before the last is taken
      tx_dfr_out <= tx_dfr_out && !(beat && cyc_left_ff == 11'h002);     // [RULE_02]
    end else begin
      tx_dfr_out <= 1'b0;
    end
  end

  // Handshake outputs are combinational from registered state
  assign tx_req_out        = req_phase;                                  // [RULE_15]
  assign tx_desc_out       = desc_ff;
  // Valid held through the final beat; a packet with one cycle uses
  // the request cycle as its framing cycle
  assign payload_valid_out = in_data && primed_ff;           // [RULE_03] [RULE_05] [RULE_06]
  // Only zero leaves while no beat is staged, reset included
  assign tx_data_out       = primed_ff ? {hi_lane, first_hi ? {tdp_pkg::DW_W{1'b0}} : lo_lane}
                                       : {tdp_pkg::DATA_W{1'b0}};        // [RULE_09]
  assign busy_out          = (state_ff != tdp_pkg::ST_IDLE);
  assign done_out          = (state_ff == tdp_pkg::ST_DONE);             // [RULE_13]
endmodule

//--- verilog/tdp_pkg.sv
// Package with constants for the transmit data-phase host controller
package tdp_pkg;
  localparam int DESC_W      = 128;  // Descriptor width
  localparam int DATA_W      = 64;   // Payload bus width, two doublewords
  localparam int DW_W        = 32;   // One doubleword
  localparam int HAS_DATA_BIT = 126; // Packet carries payload
  localparam int HDR4_BIT    = 125;  // Four-doubleword header
  localparam int LEN_HI      = 105;  // Length field top bit
  localparam int LEN_LO      = 96;   // Length field low bit
  localparam int LEN_W       = 10;   // Length field width
  localparam int ADDR2_4DW   = 2;    // Address bit 2 in a four-doubleword header
  localparam int ADDR2_3DW   = 34;   // Address bit 2 in a three-doubleword header
  localparam int MAX_VC      = 2;    // Channel index takes 0 or 1
  localparam int PAY_DEPTH   = 1024; // Largest payload in doublewords (length 0 = 1024)
  localparam int PAY_AW      = 10;   // Payload memory address width

  // Host sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_REQ  = 4'b0010,
    ST_DATA = 4'b0100,
    ST_DONE = 4'b1000
  } tdp_state_type;
endpackage

//--- verilog/tdp_pay_mem.sv
// Payload memory with registered read data
`timescale 1ns/100ps
module tdp_pay_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 1024,
  parameter int AW    = 10
) (
  input  wire logic             mclk_in,
  input  wire logic             wr_en_in,
  input  wire logic [AW-1:0]    wr_addr_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic [AW-1:0]    rd_addr_in,
  output logic      [WIDTH-1:0] rd_data_out
);
  logic [WIDTH-1:0] mem_ff [DEPTH];  // Storage array

  // Write port and registered read port, no reset so it maps to RAM
  always_ff @(posedge mclk_in) begin
    if (wr_en_in) begin
      mem_ff[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem_ff[rd_addr_in];
  end
endmodule

//--- dv/tdp_core_model.sv
// Behavioural core end of one channel: acknowledge and wait states
`timescale 1ns/100ps
module tdp_core_model (
  input  wire logic       mclk_in,
  input  wire logic       reset_n_in,
  input  wire logic       tx_req_in,
  input  wire logic       hdr4_in,
  input  wire logic [3:0] ack_dly_in,
  input  wire logic       stall_in,
  output logic            tx_ack_out,
  output logic            throttle_wait_out
);
  logic [3:0] cnt_ff;   // Cycles the request has waited
  logic       acked_ff; // Descriptor of this packet acknowledged
  logic       req_ff;   // Request seen last cycle
  logic       tog_ff;   // Alternating stall pattern
  wire logic  req_new = tx_req_in && !req_ff;
  // One-cycle acknowledge after the chosen delay, never twice a packet
  assign tx_ack_out = tx_req_in && !req_new && !acked_ff && (cnt_ff >= ack_dly_in);
  // Stall until acknowledged; a short header may meet the ack itself
  assign throttle_wait_out = (!acked_ff && !(tx_ack_out && !hdr4_in))
                             || (stall_in && tog_ff);
  // State is held on the rising edge only, as the far side would
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      {cnt_ff, acked_ff, req_ff, tog_ff} <= 7'h00;
    end else begin
      cnt_ff   <= (tx_req_in && !tx_ack_out) ? cnt_ff + 4'h1 : 4'h0;
      acked_ff <= tx_ack_out || (acked_ff && !req_new); // Stale ack dies with a new request
      req_ff   <= tx_req_in;
      tog_ff   <= !tog_ff;
    end
  end
endmodule

//--- dv/tdp_host_sva.sv
// Checker of the host side of the transmit handshake
`timescale 1ns/100ps
module tdp_host_sva (
  input wire logic         mclk_in,
  input wire logic         reset_n_in,
  input wire logic         start_in,
  input wire logic         busy_out,
  input wire logic         tx_req_out,
  input wire logic         tx_ack_in,
  input wire logic [127:0] tx_desc_out,
  input wire logic         tx_dfr_out,
  input wire logic         payload_valid_out,
  input wire logic         throttle_wait_in,
  input wire logic [63:0]  tx_data_out
);
  // Selected address bit 2 and whether more than one data cycle follows
  wire logic       off = tx_desc_out[125] ? tx_desc_out[2] : tx_desc_out[34];
  wire logic [9:0] len = tx_desc_out[105:96];
  wire logic       multi = (len == 10'h000) || ({1'b0, len} + {10'h000, off} >= 11'h003);
  wire logic       beat = payload_valid_out && !throttle_wait_in;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  a_dfr_with_req: assert property ($rose(tx_req_out) |->
    tx_dfr_out == (tx_desc_out[126] && multi)) else $error("framing wrong at request");
  a_dfr_only_req: assert property ($rose(tx_dfr_out) |-> $rose(tx_req_out))
    else $error("framing rose without request");
  a_dfr_drop: assert property ($fell(tx_dfr_out) |-> $past(beat))
    else $error("framing fell away from a beat");
  a_valid_late: assert property ($rose(tx_dfr_out) |-> !payload_valid_out)
    else $error("valid with framing edge");
  a_valid_end: assert property ($fell(payload_valid_out) |-> $past(beat))
    else $error("valid dropped without a beat");
  a_valid_follow: assert property ($rose(tx_dfr_out) |=> payload_valid_out)
    else $error("valid late after framing");
  a_valid_steady: assert property (payload_valid_out && !(beat && !tx_dfr_out) |=>
    payload_valid_out) else $error("valid gap inside packet");
  a_wait_hold: assert property (payload_valid_out && throttle_wait_in |=>
    payload_valid_out && $stable(tx_data_out)) else $error("data moved under wait");
  a_req_hold: assert property (tx_req_out && !tx_ack_in |=> tx_req_out)
    else $error("request dropped early");
  a_hdr_only: assert property (tx_req_out && !tx_desc_out[126] |->
    !tx_dfr_out && !payload_valid_out) else $error("data phase without payload");
  a_start_req: assert property (start_in && !busy_out |=> tx_req_out ##0 busy_out)
    else $error("start gave no request");
  c_wait_beat: cover property (payload_valid_out && throttle_wait_in ##1 beat);
  c_dfr_fall: cover property ($fell(tx_dfr_out));
  c_hdr_only: cover property (tx_req_out && !tx_desc_out[126]);
endmodule
bind tdp_host tdp_host_sva i_sva (.mclk_in, .reset_n_in, .start_in, .busy_out, .tx_req_out,
  .tx_ack_in, .tx_desc_out, .tx_dfr_out, .payload_valid_out, .throttle_wait_in, .tx_data_out);

//--- dv/tdp_host_test.sv
// Self-checking bench of the transmit host controller
`timescale 1ns/100ps
module tdp_host_test;
  typedef struct packed {
    logic [9:0]  len;   // Length field, 0 means 1024
    logic        hdr4;  // Four-doubleword header
    logic        off;   // Address bit 2
    logic        has;   // Payload follows
    logic        stall; // Core stalls every other cycle
    logic [3:0]  dly;   // Core acknowledge delay
    logic [10:0] nb;    // Expected data cycles
  } tdp_row_type;
  localparam tdp_row_type ROWS [9] = '{
    '{10'h001, 1'h0, 1'h0, 1'h1, 1'h0, 4'h0, 11'h001}, '{10'h001, 1'h0, 1'h1, 1'h1, 1'h0, 4'h1, 11'h001},
    '{10'h002, 1'h1, 1'h0, 1'h1, 1'h1, 4'h0, 11'h001}, '{10'h002, 1'h1, 1'h1, 1'h1, 1'h0, 4'h3, 11'h002},
    '{10'h005, 1'h0, 1'h1, 1'h1, 1'h1, 4'h0, 11'h003}, '{10'h005, 1'h1, 1'h0, 1'h1, 1'h0, 4'h5, 11'h003},
    '{10'h000, 1'h1, 1'h0, 1'h1, 1'h0, 4'h0, 11'h200}, '{10'h3ff, 1'h0, 1'h1, 1'h1, 1'h1, 4'h2, 11'h200},
    '{10'h004, 1'h1, 1'h0, 1'h0, 1'h0, 4'h1, 11'h000}};
  logic         mclk_in, reset_n_in, pay_wr_en_in, start_in, busy_out, done_out, tx_req_out;
  logic         tx_ack_in, tx_dfr_out, payload_valid_out, throttle_wait_in, stall, ack_seen;
  logic [9:0]   pay_wr_addr_in;
  logic [31:0]  pay_wr_data_in;
  logic [127:0] start_desc_in, tx_desc_out;
  logic [63:0]  tx_data_out;
  logic [3:0]   ack_dly;
  logic [63:0]  bq [$]; // Beats taken by the core
  logic         dq [$]; // Framing seen with each beat
  int           fail_count, check_count, cyc, n;
  tdp_host #(.VC_SEL(0)) i_dut (.mclk_in, .reset_n_in, .pay_wr_en_in, .pay_wr_addr_in,
    .pay_wr_data_in, .start_in, .start_desc_in, .busy_out, .done_out, .tx_req_out, .tx_desc_out,
    .tx_ack_in, .tx_dfr_out, .payload_valid_out, .throttle_wait_in, .tx_data_out);
  tdp_core_model i_core (.mclk_in, .reset_n_in, .tx_req_in(tx_req_out), .hdr4_in(tx_desc_out[125]),
    .ack_dly_in(ack_dly), .stall_in(stall), .tx_ack_out(tx_ack_in), .throttle_wait_out(throttle_wait_in));
  always #5 mclk_in = ~mclk_in;
  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Core side takes a beat only with valid high and wait low; a cycle ceiling cuts hangs
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (tx_ack_in === 1'b1) ack_seen <= 1'b1;
    if (payload_valid_out === 1'b1 && throttle_wait_in === 1'b0) begin
      bq.push_back(tx_data_out);
      dq.push_back(tx_dfr_out);
      check(ack_seen || tx_ack_in, 1'b1);
    end
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // Build the descriptor so that the unselected address bit disagrees
  task automatic start_pkt(input tdp_row_type r);
    @(negedge mclk_in);
    bq.delete();
    dq.delete();
    ack_seen = 1'b0;
    ack_dly = r.dly;
    stall = r.stall;
    start_desc_in = {1'b0, r.has, r.hdr4, 19'h00000, r.len, 96'h0};
    start_desc_in[2] = r.hdr4 ? r.off : !r.off;
    start_desc_in[34] = r.hdr4 ? !r.off : r.off;
    start_in = 1'b1;
    @(negedge mclk_in);
    start_in = 1'b0;
  endtask
  // Optionally poke a start while busy, then compare every payload-carrying lane of every beat
  task automatic finish_pkt(input tdp_row_type r, input logic poke);
    int i;
    int k;
    int lim;
    lim = (r.len == 10'h000) ? 1024 : int'(r.len);
    check(tx_desc_out, start_desc_in);
    if (poke) begin
      start_desc_in = ~start_desc_in;
      start_in = 1'b1;
      @(negedge mclk_in);
      start_in = 1'b0;
    end
    for (i = 0; i < 4000 && done_out !== 1'b1; i++) @(negedge mclk_in);
    check(done_out, 1'b1);
    check(bq.size(), r.nb);
    for (i = 0; i < bq.size(); i++) begin
      check(dq[i], i + 1 < r.nb);
      for (k = 2 * i - r.off; k < 2 * i + 2 - r.off; k++) begin
        if (k >= 0 && k < lim) check(bq[i][32 * (k - 2 * i + r.off) +: 32], 32'hc0de0000 + k);
      end
    end
  endtask
  initial begin
    {mclk_in, reset_n_in, pay_wr_en_in, start_in, stall, ack_seen} = 6'h00;
    {pay_wr_addr_in, pay_wr_data_in, start_desc_in, ack_dly} = '0;
    {fail_count, check_count, cyc} = '0;
    repeat (16) @(negedge mclk_in);
    reset_n_in = 1'b1;
    for (n = 0; n < 1024; n++) begin // Doubleword k holds a value naming k
      pay_wr_en_in = 1'b1;
      pay_wr_addr_in = n[9:0];
      pay_wr_data_in = 32'hc0de0000 + n;
      @(negedge mclk_in);
    end
    pay_wr_en_in = 1'b0;
    foreach (ROWS[r]) begin
      start_pkt(ROWS[r]);
      finish_pkt(ROWS[r], 1'b0);
      $display("Row %0d done", r);
    end
    start_pkt(ROWS[6]); // Reset in mid-packet clears every output
    repeat (20) @(negedge mclk_in);
    reset_n_in = 1'b0;
    @(negedge mclk_in);
    check({tx_req_out, tx_dfr_out, payload_valid_out, busy_out, done_out}, 5'h00);
    check(tx_data_out, 128'h0);
    reset_n_in = 1'b1;
    start_pkt(ROWS[4]);
    finish_pkt(ROWS[4], 1'b1);
    $display("Reset and start-while-busy test done");
    report_and_stop();
  end
endmodule
